// ### design/adcr_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module adcr_prescaler
  import adcr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic run_i,
  input wire logic [2:0] div_sel_i,
  // Converter clock tick
  output logic tick_o
);

  adcr_clock_divider_state_type s_r;
  adcr_clock_divider_state_type s_nxt;
  logic [7:0] last;

  // ****************************************
  // Divide by 2 to the power (sel + 1)
  // ****************************************
  assign last = 8'((ADCR_DIV_BASE << div_sel_i) - 9'h001);

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!run_i)
    begin
      s_nxt.cnt = 8'h00;
    end
    else if (s_r.cnt >= last)
    begin
      s_nxt.cnt = 8'h00;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign tick_o = s_r.tick;

endmodule
`default_nettype wire

// ### design/adcr_top.sv
// Operation
// - Resolution select 0 keeps the full 10-bit sample.
// - Resolution select 1 drops the two lowest sample bits.
// - Enable bit of control A switches the converter on or off.
// - Standby-run bit decides whether conversions continue in standby.
// - Accumulation counts 1 to 6 sum samples into one result.
// - Counts 1 to 6 give 2 to 64 samples; 7 is reserved.
// - Reference select 0 is internal, 1 is the supply rail.
// - Prescaler divides the clock by 2 up to 256 in powers of two.
// - Start bit begins a conversion, reads 1 until completion.
// - Interrupt is raised while an enabled flag is set.
`timescale 1ns/1ps
`default_nettype none
module adcr_top
  import adcr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // System status
  input wire logic standby_i,
  input wire logic halted_i,
  input wire logic trigger_i,
  // Analog core
  output adcr_core_ctrl_type core_ctrl_o,
  input wire logic [9:0] adc_data_i,
  input wire logic adc_done_i,
  // Interrupt
  output logic irq_o
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_q_r;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_q_r <= 2'b00;
    end
    else
    begin
      rst_q_r <= {rst_q_r[0], 1'b1};
    end
  end

  assign rst_n = rst_q_r[1];

  adcr_state_type s_r;
  adcr_state_type s_nxt;
  logic tick;
  logic win_match;
  logic run;
  logic access;
  logic wr;
  logic [5:0] idx;
  logic [32:0] rd;
  logic trig_edge;
  logic start_req;
  logic [15:0] smp;
  logic [15:0] acc_sum;
  logic [6:0] total;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic wr_cmd;

  // ****************************************
  // Read decode
  // ****************************************
  function automatic logic [32:0] rd_word(input adcr_state_type s,
                                          input logic [5:0] i);
    logic [31:0] d;
    logic v;
    d = '0;
    v = 1'b1;
    case (i)
      ADCR_IDX_CONTROL_A:
      begin
        d[ADCR_CA_ENABLE] = s.enable;
        d[ADCR_CA_RES_SEL] = s.res_sel;
        d[ADCR_CA_STBY_RUN] = s.standby_run;
      end
      ADCR_IDX_CONTROL_B:
        d[ADCR_LSB +: 3] = s.acc_count;
      ADCR_IDX_CONTROL_C:
      begin
        d[ADCR_CC_DIVIDER +: 3] = s.divider;
        d[ADCR_CC_REF_SEL +: 2] = s.ref_sel;
        d[ADCR_CC_CAP_SEL] = s.sample_cap;
      end
      ADCR_IDX_CONTROL_D:
      begin
        d[ADCR_CD_INTER_DLY +: 4] = s.inter_delay;
        d[ADCR_CD_AUTO_VAR] = s.auto_var;
        d[ADCR_CD_STARTUP +: 3] = s.startup_delay;
      end
      ADCR_IDX_CONTROL_E:
        d[ADCR_LSB +: 3] = s.win_mode;
      ADCR_IDX_SAMPLE_LENGTH:
        d[ADCR_LSB +: 5] = s.sample_length;
      ADCR_IDX_INPUT_SELECT:
        d[ADCR_LSB +: 5] = s.input_sel;
      ADCR_IDX_COMMAND:
        d[ADCR_CMD_START] = s.conv_start;
      ADCR_IDX_TRIGGER:
        d[ADCR_LSB] = s.trig_en;
      ADCR_IDX_IRQ_ENABLE:
        d[ADCR_LSB +: 2] = s.irq_en;
      ADCR_IDX_IRQ_FLAGS:
        d[ADCR_LSB +: 2] = s.irq_flag;
      ADCR_IDX_DEBUG:
        d[ADCR_LSB] = s.run_halted;
      ADCR_IDX_STAGING:
        d[ADCR_LSB +: 8] = s.staging;
      ADCR_IDX_RESULT:
        d[ADCR_LSB +: 16] = s.result;
      ADCR_IDX_WIN_LOW:
        d[ADCR_LSB +: 16] = s.win_low;
      ADCR_IDX_WIN_HIGH:
        d[ADCR_LSB +: 16] = s.win_high;
      ADCR_IDX_DUTY_TRIM:
        d[ADCR_LSB] = s.duty_trim;
      default:
        v = 1'b0;
    endcase
    return {v, d};
  endfunction

  // ****************************************
  // Helpers
  // ****************************************
  adcr_prescaler u_clock_divider (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n),
    .run_i     (run && (s_r.seq == ADCR_SEQ_DELAY)),
    .div_sel_i (s_r.divider),
    .tick_o    (tick)
  );

  adcr_window u_window (
    .mode_i  (s_r.win_mode),
    .low_i   (s_r.win_low),
    .high_i  (s_r.win_high),
    .value_i (s_r.result),
    .match_o (win_match)
  );

  assign run = s_r.enable && (!standby_i || s_r.standby_run)
               && (!halted_i || s_r.run_halted);
  assign idx = paddr_i[7:2];
  assign rd = rd_word(s_r, idx);
  assign access = psel_i && penable_i && s_r.pready;
  assign wr = access && pwrite_i && !s_r.pslverr;
  assign wr_cmd = wr && (idx == ADCR_IDX_COMMAND)
                  && pwdata_i[ADCR_CMD_START];
  assign trig_edge = s_r.trig_s2 && !s_r.trig_s3;
  assign start_req = wr_cmd || (s_r.trig_en && trig_edge);
  assign smp = s_r.res_sel ? 16'(adc_data_i[9:2]) : 16'(adc_data_i);
  assign acc_sum = s_r.acc + smp;
  assign total = adcr_sample_total(s_r.acc_count);

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_nxt = s_r;
    flag_set = 2'b00;
    flag_clr = 2'b00;
    s_nxt.core.sample = 1'b0;
    s_nxt.cmp_pend = 1'b0;
    s_nxt.trig_s1 = trigger_i;
    s_nxt.trig_s2 = s_r.trig_s1;
    s_nxt.trig_s3 = s_r.trig_s2;
    // Bus: data sampled at setup, zero-wait access
    s_nxt.pready = psel_i && !penable_i;
    if (psel_i && !penable_i)
    begin
      s_nxt.pslverr = !rd[32] || (paddr_i[1:0] != 2'b00);
      s_nxt.prdata = (pwrite_i || s_nxt.pslverr)
                     ? 32'h0000_0000 : rd[31:0];
    end
    else
    begin
      s_nxt.pslverr = 1'b0;
    end
    // Read clears only the flags it returned
    if (access && !pwrite_i && (idx == ADCR_IDX_IRQ_FLAGS))
    begin
      flag_clr = s_r.prdata[ADCR_LSB +: 2];
    end
    if (wr)
    begin
      case (idx)
        ADCR_IDX_CONTROL_A:
        begin
          s_nxt.enable = pwdata_i[ADCR_CA_ENABLE];
          s_nxt.res_sel = pwdata_i[ADCR_CA_RES_SEL];
          s_nxt.standby_run = pwdata_i[ADCR_CA_STBY_RUN];
        end
        ADCR_IDX_CONTROL_B:
          s_nxt.acc_count = pwdata_i[ADCR_LSB +: 3];
        ADCR_IDX_CONTROL_C:
        begin
          s_nxt.divider = pwdata_i[ADCR_CC_DIVIDER +: 3];
          s_nxt.ref_sel = pwdata_i[ADCR_CC_REF_SEL +: 2];
          s_nxt.sample_cap = pwdata_i[ADCR_CC_CAP_SEL];
          if (pwdata_i[ADCR_CC_REF_SEL +: 2] == ADCR_REF_INTERNAL)
          begin
            s_nxt.need_init = 1'b1;
          end
        end
        ADCR_IDX_CONTROL_D:
        begin
          s_nxt.inter_delay = pwdata_i[ADCR_CD_INTER_DLY +: 4];
          s_nxt.auto_var = pwdata_i[ADCR_CD_AUTO_VAR];
          s_nxt.startup_delay = pwdata_i[ADCR_CD_STARTUP +: 3];
        end
        ADCR_IDX_CONTROL_E:
          s_nxt.win_mode = pwdata_i[ADCR_LSB +: 3];
        ADCR_IDX_SAMPLE_LENGTH:
          s_nxt.sample_length = pwdata_i[ADCR_LSB +: 5];
        ADCR_IDX_INPUT_SELECT:
          s_nxt.input_sel = pwdata_i[ADCR_LSB +: 5];
        ADCR_IDX_TRIGGER:
          s_nxt.trig_en = pwdata_i[ADCR_LSB];
        ADCR_IDX_IRQ_ENABLE:
          s_nxt.irq_en = pwdata_i[ADCR_LSB +: 2];
        ADCR_IDX_IRQ_FLAGS:
          flag_clr = flag_clr | pwdata_i[ADCR_LSB +: 2];
        ADCR_IDX_DEBUG:
          s_nxt.run_halted = pwdata_i[ADCR_LSB];
        ADCR_IDX_STAGING:
          s_nxt.staging = pwdata_i[ADCR_LSB +: 8];
        ADCR_IDX_WIN_LOW:
          s_nxt.win_low = pwdata_i[ADCR_LSB +: 16];
        ADCR_IDX_WIN_HIGH:
          s_nxt.win_high = pwdata_i[ADCR_LSB +: 16];
        ADCR_IDX_DUTY_TRIM:
          s_nxt.duty_trim = pwdata_i[ADCR_LSB];
        default:
          s_nxt.staging = s_r.staging;
      endcase
    end
    // Conversion sequencer
    case (s_r.seq)
      ADCR_SEQ_IDLE:
      begin
        if (start_req && s_r.enable)
        begin
          s_nxt.conv_start = 1'b1;
          s_nxt.sel_latch = s_r.input_sel;
          s_nxt.acc = 16'h0000;
          s_nxt.samp_cnt = 7'h00;
          s_nxt.delay_cnt = ADCR_BASE_SAMPLE_TICKS
                            + 9'(s_r.sample_length)
                            + (s_r.need_init
                               ? adcr_init_ticks(s_r.startup_delay)
                               : 9'h000);
          s_nxt.need_init = 1'b0;
          s_nxt.seq = ADCR_SEQ_DELAY;
        end
      end
      ADCR_SEQ_DELAY:
      begin
        if (tick && run)
        begin
          if (s_r.delay_cnt == 9'h000)
          begin
            s_nxt.core.sample = 1'b1;
            s_nxt.seq = ADCR_SEQ_CONVERT;
          end
          else
          begin
            s_nxt.delay_cnt = s_r.delay_cnt - 9'h001;
          end
        end
      end
      ADCR_SEQ_CONVERT:
      begin
        if (adc_done_i)
        begin
          s_nxt.acc = acc_sum;
          s_nxt.samp_cnt = s_r.samp_cnt + 7'h01;
          if ((s_r.samp_cnt + 7'h01) >= total)
          begin
            s_nxt.result = acc_sum;
            s_nxt.conv_start = 1'b0;
            s_nxt.cmp_pend = 1'b1;
            flag_set[ADCR_IRQ_RESULT_READY] = 1'b1;
            s_nxt.seq = ADCR_SEQ_IDLE;
          end
          else
          begin
            s_nxt.delay_cnt = ADCR_BASE_SAMPLE_TICKS
                              + 9'(s_r.sample_length)
                              + 9'(s_r.inter_delay);
            if (s_r.auto_var)
            begin
              s_nxt.inter_delay = s_r.inter_delay + 4'h1;
            end
            s_nxt.seq = ADCR_SEQ_DELAY;
          end
        end
      end
      default:
        s_nxt.seq = ADCR_SEQ_IDLE;
    endcase
    // Compare once, after the final sample
    if (s_r.cmp_pend && win_match)
    begin
      flag_set[ADCR_IRQ_WINDOW_MATCH] = 1'b1;
    end
    if (!s_r.enable)
    begin
      s_nxt.seq = ADCR_SEQ_IDLE;
      s_nxt.conv_start = 1'b0;
      s_nxt.need_init = 1'b1;
    end
    // Set wins over clear
    s_nxt.irq_flag = (s_r.irq_flag & ~flag_clr) | flag_set;
    s_nxt.irq = |(s_nxt.irq_flag & s_nxt.irq_en);
    s_nxt.core.enable = run;
    s_nxt.core.ref_sel = s_nxt.ref_sel;
    s_nxt.core.sample_cap = s_nxt.sample_cap;
    s_nxt.core.input_sel = s_nxt.sel_latch;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= ADCR_STATE_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata_o = s_r.prdata;
  assign pready_o = s_r.pready;
  assign pslverr_o = s_r.pslverr;
  assign irq_o = s_r.irq;
  assign core_ctrl_o = s_r.core;

endmodule
`default_nettype wire

// ### design/adcr_window.sv
`timescale 1ns/1ps
`default_nettype none
module adcr_window
  import adcr_pkg::*;
(
  // Comparison setup
  input wire logic [2:0] mode_i,
  input wire logic [15:0] low_i,
  input wire logic [15:0] high_i,
  // Value under test
  input wire logic [15:0] value_i,
  output logic match_o
);

  always_comb
  begin
    case (mode_i)
      ADCR_WIN_BELOW:
        match_o = value_i < low_i;
      ADCR_WIN_ABOVE:
        match_o = value_i > high_i;
      ADCR_WIN_INSIDE:
        match_o = (value_i > low_i) && (value_i < high_i);
      ADCR_WIN_OUTSIDE:
        match_o = (value_i < low_i) || (value_i > high_i);
      default:
        match_o = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ### pkg/adcr_pkg.sv
`default_nettype none
package adcr_pkg;

  // ****************************************
  // Register indices (byte address = 4 x index)
  // ****************************************
  localparam logic [5:0] ADCR_IDX_CONTROL_A = 6'h00;
  localparam logic [5:0] ADCR_IDX_CONTROL_B = 6'h01;
  localparam logic [5:0] ADCR_IDX_CONTROL_C = 6'h02;
  localparam logic [5:0] ADCR_IDX_CONTROL_D = 6'h03;
  localparam logic [5:0] ADCR_IDX_CONTROL_E = 6'h04;
  localparam logic [5:0] ADCR_IDX_SAMPLE_LENGTH = 6'h05;
  localparam logic [5:0] ADCR_IDX_INPUT_SELECT = 6'h06;
  localparam logic [5:0] ADCR_IDX_COMMAND = 6'h08;
  localparam logic [5:0] ADCR_IDX_TRIGGER = 6'h09;
  localparam logic [5:0] ADCR_IDX_IRQ_ENABLE = 6'h0A;
  localparam logic [5:0] ADCR_IDX_IRQ_FLAGS = 6'h0B;
  localparam logic [5:0] ADCR_IDX_DEBUG = 6'h0C;
  localparam logic [5:0] ADCR_IDX_STAGING = 6'h0D;
  localparam logic [5:0] ADCR_IDX_RESULT = 6'h10;
  localparam logic [5:0] ADCR_IDX_WIN_LOW = 6'h12;
  localparam logic [5:0] ADCR_IDX_WIN_HIGH = 6'h14;
  localparam logic [5:0] ADCR_IDX_DUTY_TRIM = 6'h16;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned ADCR_CA_ENABLE = 0;
  localparam int unsigned ADCR_CA_RES_SEL = 2;
  localparam int unsigned ADCR_CA_STBY_RUN = 7;
  localparam int unsigned ADCR_CC_DIVIDER = 0;
  localparam int unsigned ADCR_CC_REF_SEL = 4;
  localparam int unsigned ADCR_CC_CAP_SEL = 6;
  localparam int unsigned ADCR_CD_INTER_DLY = 0;
  localparam int unsigned ADCR_CD_AUTO_VAR = 4;
  localparam int unsigned ADCR_CD_STARTUP = 5;
  localparam int unsigned ADCR_IRQ_RESULT_READY = 0;
  localparam int unsigned ADCR_IRQ_WINDOW_MATCH = 1;
  localparam int unsigned ADCR_CMD_START = 0;
  localparam int unsigned ADCR_LSB = 0;

  // ****************************************
  // Sequencing constants
  // ****************************************
  localparam logic [8:0] ADCR_BASE_SAMPLE_TICKS = 9'h002;
  localparam logic [8:0] ADCR_INIT_UNIT_TICKS = 9'h010;
  localparam logic [2:0] ADCR_ACC_MAX = 3'h6;
  localparam logic [2:0] ADCR_INIT_MAX = 3'h5;
  localparam logic [8:0] ADCR_DIV_BASE = 9'h002;
  localparam logic [6:0] ADCR_ONE_SAMPLE = 7'h01;

  typedef enum logic [1:0] {
    ADCR_SEQ_IDLE = 2'b00,
    ADCR_SEQ_DELAY = 2'b01,
    ADCR_SEQ_CONVERT = 2'b11
  } adcr_seq_type;

  typedef enum logic [2:0] {
    ADCR_WIN_NONE = 3'h0,
    ADCR_WIN_BELOW = 3'h1,
    ADCR_WIN_ABOVE = 3'h2,
    ADCR_WIN_INSIDE = 3'h3,
    ADCR_WIN_OUTSIDE = 3'h4
  } adcr_win_mode_type;

  localparam logic [1:0] ADCR_REF_INTERNAL = 2'h0;
  localparam logic [1:0] ADCR_REF_SUPPLY = 2'h1;

  typedef struct packed {
    logic enable;
    logic sample_cap;
    logic [1:0] ref_sel;
    logic [4:0] input_sel;
    logic sample;
  } adcr_core_ctrl_type;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } adcr_clock_divider_state_type;

  typedef struct packed {
    logic enable;
    logic standby_run;
    logic res_sel;
    logic [2:0] acc_count;
    logic sample_cap;
    logic [1:0] ref_sel;
    logic [2:0] divider;
    logic [2:0] startup_delay;
    logic auto_var;
    logic [3:0] inter_delay;
    logic [2:0] win_mode;
    logic [4:0] sample_length;
    logic [4:0] input_sel;
    logic conv_start;
    logic trig_en;
    logic [1:0] irq_en;
    logic [1:0] irq_flag;
    logic run_halted;
    logic [7:0] staging;
    logic duty_trim;
    logic [15:0] result;
    logic [15:0] win_low;
    logic [15:0] win_high;
    adcr_seq_type seq;
    logic [8:0] delay_cnt;
    logic [6:0] samp_cnt;
    logic [15:0] acc;
    logic need_init;
    logic cmp_pend;
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic [4:0] sel_latch;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    adcr_core_ctrl_type core;
  } adcr_state_type;

  localparam adcr_state_type ADCR_STATE_RESET = '0;

  // Start-up delay in converter clock ticks
  function automatic logic [8:0] adcr_init_ticks(input logic [2:0] k);
    logic [2:0] c;
    c = (k > ADCR_INIT_MAX) ? ADCR_INIT_MAX : k;
    if (c == 3'h0)
    begin
      return 9'h000;
    end
    return 9'(ADCR_INIT_UNIT_TICKS << (c - 3'h1));
  endfunction

  // Samples per conversion; reserved code acts as no accumulation
  function automatic logic [6:0] adcr_sample_total(input logic [2:0] n);
    if (n > ADCR_ACC_MAX)
    begin
      return ADCR_ONE_SAMPLE;
    end
    return 7'(ADCR_ONE_SAMPLE << n);
  endfunction

endpackage
`default_nettype wire

// ### sim/adcr_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module adcr_chk
  import adcr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Core and interrupt
  input wire adcr_core_ctrl_type core_ctrl_o,
  input wire logic irq_o
);
  logic acc_w;
  logic wr_w;
  logic [2:0] acc_hist_r;
  logic [2:0] wr_hist_r;

  assign acc_w = psel_i & penable_i;
  assign wr_w = acc_w & pwrite_i;

  // Recent bus accesses, to excuse register driven changes
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc_hist_r <= 3'h0;
      wr_hist_r <= 3'h0;
    end
    else
    begin
      acc_hist_r <= {acc_hist_r[1:0], acc_w};
      wr_hist_r <= {wr_hist_r[1:0], wr_w};
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i && pready_o;
  endsequence

  property p_ready_after_setup;
    s_setup |=> s_access;
  endproperty
  property p_ready_single;
    pready_o |=> !pready_o;
  endproperty
  property p_err_zero_data;
    pslverr_o |-> pready_o && prdata_o == 32'h00000000;
  endproperty
  property p_unmapped_err;
    s_setup and paddr_i == 8'h1C |=> pslverr_o;
  endproperty
  property p_result_upper;
    s_access and !pwrite_i && paddr_i == 8'h40 |-> prdata_o[31:16] == 16'h0000;
  endproperty
  property p_sample_pulse;
    core_ctrl_o.sample |=> !core_ctrl_o.sample;
  endproperty
  property p_sample_enabled;
    core_ctrl_o.sample |-> core_ctrl_o.enable;
  endproperty
  property p_irq_fall;
    $fell(irq_o) |-> acc_w || (|acc_hist_r);
  endproperty
  property p_ref_by_write;
    $changed(core_ctrl_o.ref_sel) |-> wr_w || (|wr_hist_r);
  endproperty

  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("no ready after setup");
  a_ready_single: assert property (p_ready_single)
    else $error("ready longer than one cycle");
  a_err_zero_data: assert property (p_err_zero_data)
    else $error("error response malformed");
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access not refused");
  a_result_upper: assert property (p_result_upper)
    else $error("result upper bits not zero");
  a_sample_pulse: assert property (p_sample_pulse)
    else $error("sample pulse too long");
  a_sample_enabled: assert property (p_sample_enabled)
    else $error("sample while disabled");
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq dropped without access");
  a_ref_by_write: assert property (p_ref_by_write)
    else $error("reference changed without write");
endmodule

bind adcr_top adcr_chk adcr_chk_i (
  .ref_clk_i, .rst_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i,
  .prdata_o, .pready_o, .pslverr_o, .core_ctrl_o, .irq_o
);
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import adcr_pkg::*;
;
  logic ref_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic standby_i, halted_i, trigger_i, adc_done_i, irq_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [9:0] adc_data_i;
  adcr_core_ctrl_type core_ctrl_o;
  int n_fail, checks_done;
  int cyc, t_go, t_smp;
  logic [9:0] samp_q[$];
  localparam logic [5:0] REG_IDX [17] = '{ADCR_IDX_CONTROL_A,
    ADCR_IDX_CONTROL_B, ADCR_IDX_CONTROL_C, ADCR_IDX_CONTROL_D,
    ADCR_IDX_CONTROL_E, ADCR_IDX_SAMPLE_LENGTH, ADCR_IDX_INPUT_SELECT,
    ADCR_IDX_COMMAND, ADCR_IDX_TRIGGER, ADCR_IDX_IRQ_ENABLE,
    ADCR_IDX_IRQ_FLAGS, ADCR_IDX_DEBUG, ADCR_IDX_STAGING, ADCR_IDX_RESULT,
    ADCR_IDX_WIN_LOW, ADCR_IDX_WIN_HIGH, ADCR_IDX_DUTY_TRIM};
  localparam logic [15:0] RD_MASK [17] = '{16'h0085, 16'h0007, 16'h0077,
    16'h00FF, 16'h0007, 16'h001F, 16'h001F, 16'h0000, 16'h0001, 16'h0003,
    16'h0000, 16'h0001, 16'h00FF, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0001};
  localparam logic [15:0] WR_MASK [17] = '{16'h0085, 16'h0007, 16'h0077,
    16'h00FF, 16'h0007, 16'h001F, 16'h001F, 16'h0000, 16'h0001, 16'h0003,
    16'h0000, 16'h0001, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0001};
  localparam logic [5:0] BAD_IDX [3] = '{6'h07, 6'h0E, 6'h3F};

  adcr_top adcr_top_i (.ref_clk_i, .rst_n_i, .paddr_i, .psel_i, .penable_i,
    .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .standby_i,
    .halted_i, .trigger_i, .core_ctrl_o, .adc_data_i, .adc_done_i, .irq_o);

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tally_and_finish;
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic [5:0] i, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge ref_clk_i);
    paddr_i <= {i, 2'b00};
    psel_i <= 1'b1;
    pwrite_i <= w;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      chk("pready", 1, 0);
      tally_and_finish;
    end
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(i, 1'b1, d, r, e);
  endtask

  task automatic rdchk(input string nm, input logic [5:0] i,
                       input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(i, 1'b0, 32'h0, r, e);
    chk(nm, x, r);
    chk("pslverr", 32'(xe), 32'(e));
  endtask

  function automatic logic [31:0] exp_sum(input logic rs);
    logic [15:0] s;
    s = 16'h0000;
    foreach (samp_q[k])
      s += rs ? 16'(samp_q[k][9:2]) : 16'(samp_q[k]);
    return 32'(s);
  endfunction

  // ****************************************
  // Clock, analog core stand-in, watchdog
  // ****************************************
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i)
    cyc <= cyc + 1;

  initial
  begin
    adc_data_i = 10'h000;
    adc_done_i = 1'b0;
    forever
    begin
      @(negedge ref_clk_i);
      if (core_ctrl_o.sample === 1'b1)
      begin
        if (samp_q.size() == 0)
          t_smp = cyc;
        repeat ($urandom_range(1, 3)) @(posedge ref_clk_i);
        adc_data_i <= 10'($urandom);
        adc_done_i <= 1'b1;
        @(posedge ref_clk_i);
        samp_q.push_back(adc_data_i);
        adc_done_i <= 1'b0;
      end
    end
  end

  initial
  begin
    repeat (60000) @(posedge ref_clk_i);
    n_fail++;
    tally_and_finish;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [31:0] d, r;
    logic e, rs;
    int n;
    void'($urandom(32'hD7F592A6));
    {rst_n_i, psel_i, penable_i, pwrite_i, standby_i} = '0;
    {halted_i, trigger_i, paddr_i, pwdata_i} = '0;
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    foreach (REG_IDX[k])
      rdchk("reset value", REG_IDX[k], 32'h0, 1'b0);
    foreach (REG_IDX[k])
    begin
      d = $urandom & 32'(WR_MASK[k]);
      wr(REG_IDX[k], d);
      rdchk("readback", REG_IDX[k], d & 32'(RD_MASK[k]), 1'b0);
      wr(REG_IDX[k], 32'h0);
    end
    foreach (BAD_IDX[k])
    begin
      wr(BAD_IDX[k], $urandom);
      rdchk("unmapped", BAD_IDX[k], 32'h0, 1'b1);
    end
    for (int a = 0; a < 8; a++)
    begin
      rs = 1'($urandom);
      wr(ADCR_IDX_CONTROL_B, 32'(a));
      wr(ADCR_IDX_CONTROL_C, 32'(a % 3) | (32'(a & 1) * 32'h50));
      wr(ADCR_IDX_CONTROL_E, 32'(a == 2) << 1);
      wr(ADCR_IDX_INPUT_SELECT, 32'(a));
      wr(ADCR_IDX_IRQ_ENABLE, 32'(a != 3));
      wr(ADCR_IDX_TRIGGER, 32'(a == 4));
      wr(ADCR_IDX_CONTROL_A, {24'h0, a == 6, 4'h0, rs, 2'b01});
      samp_q.delete();
      if (a == 4)
      begin
        trigger_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        trigger_i <= 1'b0;
      end
      else
      begin
        wr(ADCR_IDX_COMMAND, 32'h1);
        t_go = cyc;
      end
      if (a >= 5)
      begin
        standby_i <= (a != 7);
        halted_i <= (a == 7);
        repeat (100) @(posedge ref_clk_i);
        chk("standby samples", 32'(a == 6), 32'(samp_q.size() != 0));
      end
      rdchk("start bit", ADCR_IDX_COMMAND, 32'h1, 1'b0);
      {standby_i, halted_i} <= 2'b00;
      n = 0;
      do
      begin
        apb(ADCR_IDX_COMMAND, 1'b0, 32'h0, r, e);
        n++;
      end
      while (r[0] !== 1'b0 && n < 3000);
      chk("start cleared", 0, r);
      if (a < 4)
        chk("first delay", 3 * (2 << (a % 3)) + 2, t_smp - t_go);
      chk("core select", 32'(a), 32'(core_ctrl_o.input_sel));
      chk("core reference", 32'(a & 1), 32'(core_ctrl_o.ref_sel));
      chk("core cap", 32'(a & 1), 32'(core_ctrl_o.sample_cap));
      d = (a == 0 || a == 7) ? 1 : (1 << a);
      chk("sample count", d, 32'(samp_q.size()));
      rdchk("result", ADCR_IDX_RESULT, exp_sum(rs), 1'b0);
      chk("irq level", 32'(a != 3), 32'(irq_o));
      d = {30'h0, a == 2 && exp_sum(rs) != 0, 1'b1};
      rdchk("flags", ADCR_IDX_IRQ_FLAGS, d, 1'b0);
      repeat (3) @(posedge ref_clk_i);
      chk("irq cleared", 0, 32'(irq_o));
    end
    wr(ADCR_IDX_CONTROL_A, 32'h0);
    samp_q.delete();
    wr(ADCR_IDX_COMMAND, 32'h1);
    repeat (60) @(posedge ref_clk_i);
    rdchk("disabled start", ADCR_IDX_COMMAND, 32'h0, 1'b0);
    chk("disabled samples", 0, 32'(samp_q.size()));
    tally_and_finish;
  end
endmodule
`default_nettype wire
